// >>> design/wdc_cfg.svh
`ifndef WDC_CFG_SVH
`define WDC_CFG_SVH

// byte addresses on the register bus
`define WDC_ADR_LOAD 32'h4000_2580
`define WDC_ADR_COUNT 32'h4000_2584
`define WDC_ADR_CTL 32'h4000_2588
`define WDC_ADR_CLR 32'h4000_258c
`define WDC_ADR_STA 32'h4000_2598
`define WDC_ADR_EVT 32'h4000_259c
`define WDC_ADR_MASK 32'h4000_25a0

// values
`define WDC_CLR_KEY 16'hcccc
`define WDC_CTL_RST 8'he9
`define WDC_LD_RST 16'h0400
`define WDC_CNT_FIXED 16'h1000
`define WDC_STA_RSVD 16'h0020

// control fields
`define WDC_CTL_IRQ 1
`define WDC_CTL_PRE 3:2
`define WDC_CTL_EN 5
`define WDC_CTL_MOD 6

// status fields
`define WDC_STA_IRQ 0
`define WDC_STA_CLR 1
`define WDC_STA_LD 2
`define WDC_STA_CON 3
`define WDC_STA_LOCK 4

// event bits
`define WDC_EV_W 4
`define WDC_EV_TMO 0
`define WDC_EV_KEY 1
`define WDC_EV_BAD 2
`define WDC_EV_SOON 3

// timing
`define WDC_SYNC_TICKS 2'h2
`define WDC_CLR_GAP_NS 125000
`define WDC_CLK_NS 25

`endif

// >>> design/wdc_pkg.sv
package wdc_pkg;
   typedef enum logic {
      WDC_BUS_IDLE = 1'b0,
      WDC_BUS_ACK = 1'b1
   } wdc_bus_e;
   typedef logic [15:0] wdc_word_t;
endpackage

// >>> design/wdc_top.sv
`include "wdc_cfg.svh"
// Overview of operation
// - A key write to the clear register outside a clear crossing or the clear gap reloads the watchdog count and clears a pending watchdog interrupt.
// - A non-key write to the clear register outside a clear crossing or the clear gap at once raises the selected timeout action, reset or interrupt.
// - The clear register is write-only and always reads zero.
// - The status register is read-only with reserved upper bits, and writes to it do nothing.
// - The lock bit reads zero until software writes the control enable bit set, then hardware sets it.
// - The control sync bit is high while a control write is crossing to the timer domain.
// - The load sync bit is high while a load write is crossing to the timer domain.
// - The clear sync bit is high while a clear write crosses, and a key restart acts only when it completes.
// - The interrupt status bit is high exactly while a watchdog timeout interrupt is pending.
// - Every control and load change crosses into the timer domain before it takes effect.
// - A timeout occurs as the count steps from one to zero, and the next step reloads it from the fixed start or the load value per mode.
// - A timeout gives a system reset or an interrupt as the interrupt-select bit chooses.
module wdc_top #(
   parameter int CLR_GAP_CYC = (`WDC_CLR_GAP_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS,
   parameter int GAP_W = 13
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic slow_tick,
   output logic wdt_reset_req,
   output logic irq
);
   wdc_pkg::wdc_bus_e bus_st, next_bus_st;
   logic [31:0] next_dat;
   logic [7:0] ctl, next_ctl, t_ctl, next_t_ctl;
   wdc_pkg::wdc_word_t ld, next_ld, t_ld, next_t_ld, count, next_count, wd, status, reload;
   logic ctl_written, next_ctl_written, lock, next_lock;
   logic [2:0] pend, next_pend, sync_done;
   logic [1:0] scnt [3];
   logic [1:0] next_scnt [3];
   logic clr_key_ok, next_clr_key_ok, wip, next_wip, next_rst_req;
   logic [GAP_W-1:0] gap_cnt, next_gap_cnt;
   logic [`WDC_EV_W-1:0] evt, next_evt, mask, next_mask;
   logic [11:0] pre_cnt, next_pre, pre_last;
   logic req, wr, tmo, bad_key, clr_ok, key_done;

   // a write takes effect on the edge where the master sees ack
   assign req = wb_cyc_i && wb_stb_i;
   assign wr = req && wb_we_i && wb_ack_o;
   assign wd = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
   assign wb_ack_o = (bus_st == wdc_pkg::WDC_BUS_ACK);
   assign irq = |(evt & mask);
   assign status = `WDC_STA_RSVD | {11'h000, lock, pend[0], pend[1], pend[2], wip};
   assign clr_ok = (gap_cnt == '0) && !pend[2];
   assign bad_key = wr && (wb_adr_i == `WDC_ADR_CLR) && clr_ok && (wd != `WDC_CLR_KEY);
   assign key_done = sync_done[2] && clr_key_ok;

   // a channel finishes on its last slow tick
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         sync_done[i] = slow_tick && pend[i] && (scnt[i] == `WDC_SYNC_TICKS - 2'h1);
      end
   end

   // bus answer: one wait state, then ack for one cycle
   always_comb begin
      next_bus_st = (req && !wb_ack_o) ? wdc_pkg::WDC_BUS_ACK : wdc_pkg::WDC_BUS_IDLE;
      next_dat = 32'h0000_0000;
      if (req && !wb_ack_o && !wb_we_i) begin
         unique case (wb_adr_i)
            `WDC_ADR_LOAD: next_dat = {16'h0000, ld};
            `WDC_ADR_COUNT: next_dat = {16'h0000, count};
            `WDC_ADR_CTL: next_dat = {24'h000000, ctl};
            `WDC_ADR_STA: next_dat = {16'h0000, status};
            `WDC_ADR_EVT: next_dat = {28'h0000000, evt};
            `WDC_ADR_MASK: next_dat = {28'h0000000, mask};
            default: next_dat = 32'h0000_0000; // clear reads zero
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bus_st <= wdc_pkg::WDC_BUS_IDLE;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         bus_st <= next_bus_st;
         wb_dat_o <= next_dat;
      end
   end

   // core side registers, sync tracking and events
   always_comb begin
      next_ctl = ctl;
      next_ld = ld;
      next_ctl_written = ctl_written;
      next_lock = lock;
      next_pend = pend;
      next_scnt = scnt;
      next_clr_key_ok = clr_key_ok;
      next_gap_cnt = (gap_cnt == '0) ? gap_cnt : gap_cnt - GAP_W'(1);
      next_wip = wip;
      next_evt = evt;
      next_mask = mask;
      next_rst_req = 1'b0;
      // tick the crossing counters; a fresh control or load write restarts its channel, a clear write during a clear crossing or the clear gap is dropped
      for (int i = 0; i < 3; i++) begin
         if (sync_done[i]) begin
            next_pend[i] = 1'b0;
            next_scnt[i] = 2'h0;
         end else if (slow_tick && pend[i]) begin
            next_scnt[i] = scnt[i] + 2'h1;
         end
      end
      if (wr) begin
         unique case (wb_adr_i)
            `WDC_ADR_CTL: begin
               next_ctl = wd[7:0];
               // disable honoured only on the first control write
               if (ctl_written && !wd[`WDC_CTL_EN]) next_ctl[`WDC_CTL_EN] = ctl[`WDC_CTL_EN];
               next_ctl_written = 1'b1;
               if (wd[`WDC_CTL_EN]) next_lock = 1'b1;
               next_pend[0] = 1'b1;
               next_scnt[0] = 2'h0;
            end
            `WDC_ADR_LOAD: begin
               next_ld = wd;
               next_pend[1] = 1'b1;
               next_scnt[1] = 2'h0;
            end
            `WDC_ADR_CLR: begin
               if (clr_ok) begin
                  next_pend[2] = 1'b1;
                  next_scnt[2] = 2'h0;
                  next_clr_key_ok = (wd == `WDC_CLR_KEY);
                  next_gap_cnt = GAP_W'(CLR_GAP_CYC - 1);
               end else begin
                  next_evt[`WDC_EV_SOON] = 1'b1; // too close to the last one
               end
            end
            `WDC_ADR_EVT: next_evt = evt & ~wd[`WDC_EV_W-1:0];
            `WDC_ADR_MASK: next_mask = wd[`WDC_EV_W-1:0];
            default: next_evt = next_evt; // status and unmapped writes ignored
         endcase
      end
      // key clear lands only when synced
      if (key_done) begin
         next_wip = 1'b0;
         next_evt[`WDC_EV_KEY] = 1'b1;
      end
      // timeout or bad key: set wins over the key clear
      if (tmo || bad_key) begin
         if (t_ctl[`WDC_CTL_IRQ]) begin
            next_wip = 1'b1;
            next_evt[`WDC_EV_TMO] = 1'b1;
         end else begin
            next_rst_req = 1'b1;
         end
      end
      if (bad_key) next_evt[`WDC_EV_BAD] = 1'b1;
      // hardware sets win over the w1c clear
      if (sync_done[2] && clr_key_ok) next_evt[`WDC_EV_KEY] = 1'b1;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctl <= `WDC_CTL_RST;
         ld <= `WDC_LD_RST;
         ctl_written <= 1'b0;
         lock <= 1'b0;
         pend <= 3'h0;
         scnt <= '{default: 2'h0};
         clr_key_ok <= 1'b0;
         gap_cnt <= '0;
         wip <= 1'b0;
         evt <= '0;
         mask <= '0;
         wdt_reset_req <= 1'b0;
      end else begin
         ctl <= next_ctl;
         ld <= next_ld;
         ctl_written <= next_ctl_written;
         lock <= next_lock;
         pend <= next_pend;
         scnt <= next_scnt;
         clr_key_ok <= next_clr_key_ok;
         gap_cnt <= next_gap_cnt;
         wip <= next_wip;
         evt <= next_evt;
         mask <= next_mask;
         wdt_reset_req <= next_rst_req;
      end
   end

   // timer side, advanced only on slow ticks
   always_comb begin
      pre_last = 12'((13'h0001 << {t_ctl[`WDC_CTL_PRE], 2'b00}) - 13'h0001);
      reload = t_ctl[`WDC_CTL_MOD] ? t_ld : `WDC_CNT_FIXED;
      next_count = count;
      next_pre = pre_cnt;
      next_t_ctl = t_ctl;
      next_t_ld = t_ld;
      tmo = 1'b0;
      if (slow_tick && t_ctl[`WDC_CTL_EN]) begin
         if (pre_cnt >= pre_last) begin
            next_pre = 12'h000;
            next_count = (count == 16'h0000) ? reload : count - 16'h0001;
            tmo = (count == 16'h0001);
         end else begin
            next_pre = pre_cnt + 12'h001;
         end
      end
      // crossed control and key writes, and crossed load writes in load mode, override the running count
      if (sync_done[0]) begin
         next_t_ctl = ctl;
         next_count = ctl[`WDC_CTL_MOD] ? t_ld : `WDC_CNT_FIXED;
         next_pre = 12'h000;
      end
      if (sync_done[1]) begin
         next_t_ld = ld;
         if (t_ctl[`WDC_CTL_MOD]) next_count = ld;
      end
      if (key_done) begin
         next_count = reload;
         next_pre = 12'h000;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         t_ctl <= `WDC_CTL_RST;
         t_ld <= `WDC_LD_RST;
         count <= `WDC_CNT_FIXED;
         pre_cnt <= 12'h000;
      end else begin
         t_ctl <= next_t_ctl;
         t_ld <= next_t_ld;
         count <= next_count;
         pre_cnt <= next_pre;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   key_clear_irq_a: assert property (key_done |=> !wip || $past(tmo))
      else $error("key clear left interrupt pending");
   key_reload_a: assert property (key_done && !sync_done[0] && !sync_done[1] |=> count == $past(reload))
      else $error("key clear did not reload count");
   bad_key_act_a: assert property (bad_key |=> wip || wdt_reset_req)
      else $error("bad key gave no timeout action");
   clear_reads_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `WDC_ADR_CLR |-> wb_dat_o == 0)
      else $error("clear register read non-zero");
   status_ro_a: assert property (wr && wb_adr_i == `WDC_ADR_STA && !tmo && !key_done |=> wip == $past(wip))
      else $error("status write changed state");
   lock_set_a: assert property (wr && wb_adr_i == `WDC_ADR_CTL && wd[`WDC_CTL_EN] |=> lock ##1 lock)
      else $error("lock not set after enable write");
   ctl_sync_a: assert property (wr && wb_adr_i == `WDC_ADR_CTL |=> status[`WDC_STA_CON] && t_ctl == $past(t_ctl))
      else $error("control sync bit not raised");
   load_write_pending_a: assert property (wr && wb_adr_i == `WDC_ADR_LOAD |=> status[`WDC_STA_LD])
      else $error("load sync bit not raised");
   clr_sync_a: assert property (wr && wb_adr_i == `WDC_ADR_CLR && clr_ok |=> status[`WDC_STA_CLR])
      else $error("clear sync bit not raised");
   tmo_action_a: assert property (tmo && !t_ctl[`WDC_CTL_IRQ] |=> wdt_reset_req ##1 !wdt_reset_req[*1])
      else $error("timeout reset pulse wrong");
   tmo_irq_a: assert property (tmo && t_ctl[`WDC_CTL_IRQ] |=> wip && status[`WDC_STA_IRQ])
      else $error("timeout interrupt not pending");
   wip_hold_a: assert property ($fell(wip) |-> $past(key_done))
      else $error("interrupt cleared without key sync");

   // lock is sticky until reset
   lock_hold_a: assert property (lock |=> lock)
      else $error("lock bit dropped");
   // interrupt pending only ever rises from a timeout or a bad key
   wip_set_a: assert property ($rose(wip) |-> $past(tmo || bad_key))
      else $error("interrupt pending without a cause");
   // the reset pulse needs a cause and the reset action selected
   rst_cause_a: assert property (wdt_reset_req |-> $past(tmo || bad_key) && !$past(t_ctl[`WDC_CTL_IRQ]))
      else $error("reset request without a cause");
   // wrap from zero with no crossing write landing in the same cycle
   logic wrap_zero;
   assign wrap_zero = slow_tick && t_ctl[`WDC_CTL_EN] && (pre_cnt >= pre_last) && (count == 16'h0000)
      && !sync_done[0] && !sync_done[1] && !key_done;
   zero_reload_a: assert property (wrap_zero |=> count == $past(reload))
      else $error("count did not reload at zero");
   // a clear write during a clear crossing or the clear gap is dropped but flagged
   clr_busy_a: assert property (wr && wb_adr_i == `WDC_ADR_CLR && !clr_ok |=> evt[`WDC_EV_SOON])
      else $error("dropped clear write not flagged");

   // main scenarios seen at least once
   key_cycle_c: cover property (wr && wb_adr_i == `WDC_ADR_CLR ##[1:40] key_done);
   bad_key_c: cover property (bad_key);
   tmo_irq_c: cover property (tmo && t_ctl[`WDC_CTL_IRQ]);
   reset_req_c: cover property (wdt_reset_req);
   irq_out_c: cover property ($rose(irq));
endmodule

// >>> bench/tb_top.sv
`include "wdc_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst_b, cyc, stb, we, slow_tick;
   logic [31:0] adr, wdat;
   logic [3:0] sel;
   logic [31:0] rdat, st;
   logic wb_ack_o, wdt_reset_req, irq;
   logic [31:0] wb_dat_o;
   int err_count, num_checks, pulses, snap;

   // short clear gap keeps the run brief
   wdc_top #(.CLR_GAP_CYC(8), .GAP_W(13)) DUT (
      .clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .slow_tick(slow_tick), .wdt_reset_req(wdt_reset_req), .irq(irq)
   );

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // reset request is a one-cycle pulse, so count every cycle it is seen
   always @(posedge clock) begin
      if (wdt_reset_req === 1'b1) pulses++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // classic cycle: hold the request until ack is sampled high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'h3;
      // no local limit: a missing ack is caught by the watchdog
      do begin
         @(posedge clock);
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000, rdat);
      chk(rdat, exp);
   endtask

   // slow oscillator edges, with room for the pending bit to drop
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clock);
         slow_tick <= 1'b1;
         @(posedge clock);
         slow_tick <= 1'b0;
         repeat (2) @(posedge clock);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      wrap_up();
   end

   initial begin
      {cyc, stb, we, slow_tick} = 4'h0;
      adr = 32'h0000_0000;
      wdat = 32'h0000_0000;
      sel = 4'h0;
      rst_b = 1'b0;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      rdchk(`WDC_ADR_STA, 32'h0000_0020);
      rdchk(`WDC_ADR_CLR, 32'h0000_0000);
      rdchk(32'h4000_25f0, 32'h0000_0000);
      wr(`WDC_ADR_STA, 32'h0000_ffff);
      rdchk(`WDC_ADR_STA, 32'h0000_0020);
      $display("test reset_and_readonly done");
      wr(`WDC_ADR_LOAD, 32'h0000_0003);
      rdchk(`WDC_ADR_STA, 32'h0000_0024);
      ticks(2);
      rdchk(`WDC_ADR_STA, 32'h0000_0020);
      wr(`WDC_ADR_CTL, 32'h0000_00eb);
      rdchk(`WDC_ADR_STA, 32'h0000_0038);
      ticks(2);
      rdchk(`WDC_ADR_STA, 32'h0000_0030);
      $display("test sync_bits done");
      wr(`WDC_ADR_MASK, 32'h0000_000f);
      wr(`WDC_ADR_CLR, 32'h0000_1234);
      rdchk(`WDC_ADR_STA, 32'h0000_0033);
      chk({31'h0, irq}, 32'h1);
      ticks(2);
      rdchk(`WDC_ADR_STA, 32'h0000_0031);
      wr(`WDC_ADR_CLR, 32'h0000_cccc);
      wr(`WDC_ADR_CLR, 32'h0000_cccc);
      rdchk(`WDC_ADR_STA, 32'h0000_0033);
      ticks(2); // let the key write finish crossing before moving on
      rdchk(`WDC_ADR_STA, 32'h0000_0030);
      xfer(1'b0, `WDC_ADR_EVT, 32'h0000_0000, rdat);
      chk(rdat & 32'h0000_000e, 32'h0000_000e);
      wr(`WDC_ADR_EVT, 32'h0000_000f);
      rdchk(`WDC_ADR_EVT, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
      $display("test clear_key_irq done");
      // interrupt select back to reset action
      wr(`WDC_ADR_CTL, 32'h0000_00e9);
      ticks(2);
      snap = pulses;
      wr(`WDC_ADR_CLR, 32'h0000_5555);
      repeat (3) @(posedge clock);
      chk(pulses, snap + 1);
      ticks(2);
      rdchk(`WDC_ADR_STA, 32'h0000_0030); // all sync bits clear before the next control write
      $display("test bad_key_reset done");
      // no prescale, reload from load value, interrupt on timeout
      wr(`WDC_ADR_CTL, 32'h0000_00e2);
      ticks(2);
      st = 32'h0;
      for (int i = 0; i < 8 && st[0] !== 1'b1; i++) begin
         ticks(1);
         xfer(1'b0, `WDC_ADR_STA, 32'h0000_0000, st);
      end
      chk(st & 32'h1, 32'h1);
      rdchk(`WDC_ADR_COUNT, 32'h0000_0000);
      ticks(1);
      rdchk(`WDC_ADR_COUNT, 32'h0000_0003);
      chk({31'h0, irq}, 32'h1);
      $display("test timeout_reload done");
      // reset action on a counted timeout, reload from load value
      wr(`WDC_ADR_CTL, 32'h0000_00e0);
      ticks(2);
      snap = pulses;
      ticks(3);
      chk(pulses, snap + 1);
      rdchk(`WDC_ADR_COUNT, 32'h0000_0000);
      $display("test timeout_reset done");
      // mid-run reset brings back the reset state
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      chk({31'h0, irq}, 32'h0);
      rdchk(`WDC_ADR_STA, 32'h0000_0020);
      rdchk(`WDC_ADR_COUNT, 32'h0000_1000);
      $display("test midrun_reset done");
      wrap_up();
   end
endmodule
